//--- rtl/cwt_pkg.sv
// Constants and carrier types for the compare waveform timer
package cwt_pkg;
    localparam int unsigned CNT_W = 8;
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_FORCE = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_CMPA  = 8'h0C;
    localparam logic [7:0] OFS_CMPB  = 8'h10;
    localparam logic [7:0] OFS_FLAGS = 8'h14;
    localparam logic [7:0] OFS_IRQEN = 8'h18;
    localparam logic [7:0] OFS_PINS  = 8'h1C;
    // Wave mode codes
    localparam logic [2:0] WM_NORMAL = 3'h0;
    localparam logic [2:0] WM_PC_FF  = 3'h1;
    localparam logic [2:0] WM_CTC    = 3'h2;
    localparam logic [2:0] WM_FP_FF  = 3'h3;
    localparam logic [2:0] WM_PC_A   = 3'h5;
    localparam logic [2:0] WM_FP_A   = 3'h7;
    // Pin action codes
    localparam logic [1:0] PA_NONE   = 2'h0;
    localparam logic [1:0] PA_TOGGLE = 2'h1;
    localparam logic [1:0] PA_CLEAR  = 2'h2;
    localparam logic [1:0] PA_SET    = 2'h3;
    localparam logic [2:0] CS_STOP   = 3'h0;
    localparam logic [7:0] CNT_MAX   = 8'hFF;
    localparam logic [7:0] CNT_BOT   = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam int unsigned FLG_OVF  = 0;
    localparam int unsigned FLG_A    = 1;
    localparam int unsigned FLG_B    = 2;
    localparam int unsigned PIN_DIR_A = 0;
    localparam int unsigned PIN_DIR_B = 1;
    localparam int unsigned PIN_PORT_A = 2;
    localparam int unsigned PIN_PORT_B = 3;
    localparam int unsigned PIN_STATE_A = 4;
    localparam int unsigned PIN_STATE_B = 5;

    // Control register layout, MSB first down to wave mode
    typedef struct packed {
        logic [2:0] clock_source_sel;
        logic [1:0] pin_action_field_b;
        logic [1:0] pin_action_field_a;
        logic       rsvd;
        logic [2:0] wave_mode_sel;
    } cwt_ctrl_t;
    localparam cwt_ctrl_t CTRL_RST = '0;

    typedef struct packed {
        logic match_b_flag;
        logic match_a_flag;
        logic overflow_flag;
    } cwt_flags_t;
endpackage

//--- rtl/cwt_timer.sv
// Compare and waveform timer with AHB-Lite register slave
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module cwt_timer #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              timer_tick,
    input  wire logic [2:0]        irq_ack,
    output logic [2:0]             irq_req,
    output logic                   wave_pin_a,
    output logic                   wave_pin_a_oe_n,
    output logic                   wave_pin_b,
    output logic                   wave_pin_b_oe_n
);
    localparam int unsigned CW = cwt_pkg::CNT_W;

    if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
        $error("ADDR_W must lie between 5 and 8");
    end

    cwt_pkg::cwt_ctrl_t  ctrl_q;
    cwt_pkg::cwt_flags_t flags_q;
    logic [CW-1:0]       count_value_q;
    logic [CW-1:0]       compare_a_value_q;
    logic [CW-1:0]       compare_b_value_q;
    logic [CW-1:0]       buf_a_q;
    logic [CW-1:0]       buf_b_q;
    logic [2:0]          irq_en_q;
    logic [3:0]          pins_q;
    logic                wave_out_state_a_q;
    logic                wave_out_state_b_q;
    logic                block_q;
    logic                count_down_q;
    logic                wr_q;
    logic [7:0]          addr_q;
    logic [31:0]         hrdata_q;
    logic                hreadyout_q;
    logic [2:0]          irq_q;
    logic                pin_a_q;
    logic                pin_a_oe_n_q;
    logic                pin_b_q;
    logic                pin_b_oe_n_q;

    logic          addr_ph;
    logic [7:0]    haddr8;
    logic          wr_ctrl;
    logic          wr_force;
    logic          wr_count;
    logic          wr_cmpa;
    logic          wr_cmpb;
    logic          wr_flags;
    logic          wr_irqen;
    logic          wr_pins;
    logic [2:0]    wm;
    logic          pwm;
    logic          fast;
    logic          tick;
    logic [CW-1:0] top;
    logic          at_top;
    logic          hit_a;
    logic          hit_b;
    logic          frc_a;
    logic          frc_b;
    logic          ovf_evt;
    logic [CW-1:0] count_d;
    logic          down_d;
    logic [31:0]   rd_mux;

    // Bus decode
    assign addr_ph  = hsel && htrans == cwt_pkg::HTRANS_NONSEQ && hready;
    assign haddr8   = 8'(haddr);
    assign wr_ctrl  = wr_q && addr_q == cwt_pkg::OFS_CTRL;
    assign wr_force = wr_q && addr_q == cwt_pkg::OFS_FORCE;
    assign wr_count = wr_q && addr_q == cwt_pkg::OFS_COUNT;
    assign wr_cmpa  = wr_q && addr_q == cwt_pkg::OFS_CMPA;
    assign wr_cmpb  = wr_q && addr_q == cwt_pkg::OFS_CMPB;
    assign wr_flags = wr_q && addr_q == cwt_pkg::OFS_FLAGS;
    assign wr_irqen = wr_q && addr_q == cwt_pkg::OFS_IRQEN;
    assign wr_pins  = wr_q && addr_q == cwt_pkg::OFS_PINS;

    // Mode decode
    assign wm   = ctrl_q.wave_mode_sel;
    assign pwm  = wm[0];
    assign fast = pwm && wm[1];
    assign tick = timer_tick && ctrl_q.clock_source_sel != cwt_pkg::CS_STOP;
    assign top  = (wm == cwt_pkg::WM_CTC || wm == cwt_pkg::WM_PC_A
                   || wm == cwt_pkg::WM_FP_A) ? compare_a_value_q : cwt_pkg::CNT_MAX;
    assign at_top = count_value_q == top;

    // Matches
    assign hit_a = tick && !block_q && !wr_count && count_value_q == compare_a_value_q;
    assign hit_b = tick && !block_q && !wr_count && count_value_q == compare_b_value_q;
    assign frc_a = wr_force && hwdata[0] && !pwm;
    assign frc_b = wr_force && hwdata[1] && !pwm;

    // Counter next value
    always_comb begin
        count_d = count_value_q;
        down_d  = count_down_q;
        ovf_evt = 1'b0;
        if (!pwm || fast) begin
            count_d = at_top ? cwt_pkg::CNT_BOT : CW'(count_value_q + 1'b1);
            down_d  = 1'b0;
            if (fast) begin
                ovf_evt = at_top;
            end else begin
                ovf_evt = count_value_q == cwt_pkg::CNT_MAX;
            end
        end else if (count_down_q) begin
            if (count_value_q == cwt_pkg::CNT_BOT) begin
                count_d = CW'(count_value_q + 1'b1);
                down_d  = 1'b0;
            end else begin
                count_d = CW'(count_value_q - 1'b1);
                ovf_evt = count_d == cwt_pkg::CNT_BOT;
            end
        end else if (at_top) begin
            count_d = CW'(count_value_q - 1'b1);
            down_d  = 1'b1;
        end else begin
            count_d = CW'(count_value_q + 1'b1);
        end
    end

    // Next output state for one channel
    function automatic logic wave_next(input logic [1:0] act, input logic st, input logic hit,
                                       input logic frc, input logic bot, input logic down,
                                       input logic [2:0] mode, input logic is_a);
        logic r;
        r = st;
        if (act == cwt_pkg::PA_NONE) begin
            r = st;
        end else if (!mode[0]) begin
            if (hit || frc) begin
                case (act)
                    cwt_pkg::PA_TOGGLE: r = ~st;
                    cwt_pkg::PA_CLEAR:  r = 1'b0;
                    default:            r = 1'b1;
                endcase
            end
        end else if (act == cwt_pkg::PA_TOGGLE) begin
            if (is_a && mode[2] && hit) begin
                r = ~st;
            end
        end else if (mode[1]) begin
            if (hit) begin
                r = act[0];
            end else if (bot) begin
                r = ~act[0];
            end
        end else if (hit) begin
            r = act[0] ^ down;
        end
        return r;
    endfunction

    // Bus address phase and read data
    always_comb begin
        rd_mux = '0;
        if (haddr8 == cwt_pkg::OFS_CTRL) begin
            rd_mux = 32'(ctrl_q);
        end else if (haddr8 == cwt_pkg::OFS_COUNT) begin
            rd_mux = 32'(count_value_q);
        end else if (haddr8 == cwt_pkg::OFS_CMPA) begin
            rd_mux = 32'(pwm ? buf_a_q : compare_a_value_q);
        end else if (haddr8 == cwt_pkg::OFS_CMPB) begin
            rd_mux = 32'(pwm ? buf_b_q : compare_b_value_q);
        end else if (haddr8 == cwt_pkg::OFS_FLAGS) begin
            rd_mux = 32'(flags_q);
        end else if (haddr8 == cwt_pkg::OFS_IRQEN) begin
            rd_mux = 32'(irq_en_q);
        end else if (haddr8 == cwt_pkg::OFS_PINS) begin
            rd_mux = 32'({wave_out_state_b_q, wave_out_state_a_q, pins_q});
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q        <= 1'b0;
            addr_q      <= '0;
            hrdata_q    <= '0;
            hreadyout_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            wr_q        <= addr_ph && hwrite;
            if (addr_ph) begin
                addr_q <= haddr8;
            end
            if (addr_ph && !hwrite) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q   <= cwt_pkg::CTRL_RST;
            irq_en_q <= '0;
            pins_q   <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= cwt_pkg::cwt_ctrl_t'(hwdata[$bits(cwt_pkg::cwt_ctrl_t)-1:0]);
            end
            if (wr_irqen) begin
                irq_en_q <= hwdata[2:0];
            end
            if (wr_pins) begin
                pins_q <= hwdata[3:0];
            end
        end
    end

    // Counter, direction and match blocking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_value_q <= '0;
            count_down_q  <= 1'b0;
            block_q       <= 1'b0;
        end else begin
            if (wr_count) begin
                count_value_q <= hwdata[CW-1:0];
                block_q       <= 1'b1;
            end else if (tick) begin
                count_value_q <= count_d;
                count_down_q  <= down_d;
                block_q       <= 1'b0;
            end
        end
    end

    // Compare values and buffers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_a_value_q <= '0;
            compare_b_value_q <= '0;
            buf_a_q           <= '0;
            buf_b_q           <= '0;
        end else begin
            if (wr_cmpa) begin
                buf_a_q <= hwdata[CW-1:0];
            end
            if (wr_cmpb) begin
                buf_b_q <= hwdata[CW-1:0];
            end
            if (!pwm) begin
                if (wr_cmpa) begin
                    compare_a_value_q <= hwdata[CW-1:0];
                end
                if (wr_cmpb) begin
                    compare_b_value_q <= hwdata[CW-1:0];
                end
            end else if (tick && !wr_count && (fast ? at_top : (at_top && !count_down_q))) begin
                compare_a_value_q <= buf_a_q;
                compare_b_value_q <= buf_b_q;
            end
        end
    end

    // Flags: set wins over either clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if ((wr_flags && hwdata[i]) || irq_ack[i]) begin
                    flags_q[i] <= 1'b0;
                end
            end
            if (tick && !wr_count && ovf_evt) begin
                flags_q.overflow_flag <= 1'b1;
            end
            if (hit_a) begin
                flags_q.match_a_flag <= 1'b1;
            end
            if (hit_b) begin
                flags_q.match_b_flag <= 1'b1;
            end
        end
    end

    // Output state bits, kept across mode changes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wave_out_state_a_q <= 1'b0;
            wave_out_state_b_q <= 1'b0;
        end else begin
            wave_out_state_a_q <= wave_next(ctrl_q.pin_action_field_a, wave_out_state_a_q,
                                            hit_a, frc_a, tick && at_top && !wr_count,
                                            count_down_q, wm, 1'b1);
            wave_out_state_b_q <= wave_next(ctrl_q.pin_action_field_b, wave_out_state_b_q,
                                            hit_b, frc_b, tick && at_top && !wr_count,
                                            count_down_q, wm, 1'b0);
        end
    end

    // Pins and interrupt requests
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q        <= '0;
            pin_a_q      <= 1'b0;
            pin_b_q      <= 1'b0;
            pin_a_oe_n_q <= 1'b1;
            pin_b_oe_n_q <= 1'b1;
        end else begin
            irq_q   <= flags_q & irq_en_q & ~irq_ack;
            pin_a_q <= (ctrl_q.pin_action_field_a != cwt_pkg::PA_NONE)
                       ? wave_out_state_a_q : pins_q[cwt_pkg::PIN_PORT_A];
            pin_b_q <= (ctrl_q.pin_action_field_b != cwt_pkg::PA_NONE)
                       ? wave_out_state_b_q : pins_q[cwt_pkg::PIN_PORT_B];
            pin_a_oe_n_q <= !pins_q[cwt_pkg::PIN_DIR_A];
            pin_b_oe_n_q <= !pins_q[cwt_pkg::PIN_DIR_B];
        end
    end

    assign hrdata          = hrdata_q;
    assign hreadyout       = hreadyout_q;
    assign hresp           = 1'b0;
    assign irq_req         = irq_q;
    assign wave_pin_a      = pin_a_q;
    assign wave_pin_a_oe_n = pin_a_oe_n_q;
    assign wave_pin_b      = pin_b_q;
    assign wave_pin_b_oe_n = pin_b_oe_n_q;
endmodule

//--- sim/cwt_timer_sva.sv
// Port level assertions for the compare waveform timer
`timescale 1ns/1ps
module cwt_timer_sva #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [2:0]        hsize,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic              timer_tick,
    input wire logic [2:0]        irq_ack,
    input wire logic [2:0]        irq_req,
    input wire logic              wave_pin_a,
    input wire logic              wave_pin_a_oe_n,
    input wire logic              wave_pin_b,
    input wire logic              wave_pin_b_oe_n
);
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [7:0] ctrl_q;
    logic [2:0] en_q;
    logic [3:0] pins_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Write address capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= hsel && hwrite && (htrans == cwt_pkg::HTRANS_NONSEQ);
            wr_addr_q <= 8'(haddr);
        end
    end

    // Shadow of configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= 8'h00;
            en_q   <= 3'h0;
            pins_q <= 4'h0;
        end else if (wr_pend_q && hready) begin
            if (wr_addr_q == cwt_pkg::OFS_CTRL) begin
                ctrl_q <= hwdata[7:0];
            end
            if (wr_addr_q == cwt_pkg::OFS_IRQEN) begin
                en_q <= hwdata[2:0];
            end
            if (wr_addr_q == cwt_pkg::OFS_PINS) begin
                pins_q <= hwdata[3:0];
            end
        end
    end

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("Response is not OKAY");
    a_ready_high: assert property ($past(hresetn) |-> hreadyout)
        else $error("Ready dropped after reset");
    a_oe_dir_a: assert property (wave_pin_a_oe_n == !$past(pins_q[0]))
        else $error("Pin A enable does not follow direction");
    a_oe_dir_b: assert property (wave_pin_b_oe_n == !$past(pins_q[1]))
        else $error("Pin B enable does not follow direction");
    a_pin_port_a: assert property (
        $past(ctrl_q[5:4]) == 2'h0 |-> wave_pin_a == $past(pins_q[2]))
        else $error("Pin A does not show port value");
    a_irq_masked: assert property ((irq_req & ~$past(en_q)) == 3'h0)
        else $error("Request raised while disabled");
    a_irq_after_tick: assert property (
        $rose(irq_req[1]) |-> $past(timer_tick, 2) || $past(irq_ack[1])
            || $past(irq_ack[1], 2) || ($past(en_q[1]) && !$past(en_q[1], 2)))
        else $error("Match request rose without a tick");
    a_ack_clears: assert property (
        irq_ack[1] && !timer_tick |=> !irq_req[1])
        else $error("Serviced request stayed high");
    a_pin_port_b: assert property (
        $past(ctrl_q[7:6]) == 2'h0 |-> wave_pin_b == $past(pins_q[3]))
        else $error("Pin B does not show port value");
endmodule

bind cwt_timer cwt_timer_sva #(.ADDR_W(ADDR_W)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_tick(timer_tick), .irq_ack(irq_ack), .irq_req(irq_req),
    .wave_pin_a(wave_pin_a), .wave_pin_a_oe_n(wave_pin_a_oe_n),
    .wave_pin_b(wave_pin_b), .wave_pin_b_oe_n(wave_pin_b_oe_n)
);

//--- sim/cwt_timer_tb.sv
// Self-checking bench for the compare waveform timer
`timescale 1ns/1ps
module cwt_timer_tb;
    logic        hclk;
    logic        hresetn;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        timer_tick;
    logic [2:0]  irq_ack;
    logic [2:0]  irq_req;
    logic        pin_a, oe_a_n, pin_b, oe_b_n;
    logic [31:0] r;
    int          fails = 0;
    int          checks = 0;
    int          cyc = 0;
    logic [31:0] fc [5] = '{32'h20, 32'h30, 32'h10, 32'h00, 32'h33};
    logic [31:0] fs [5] = '{32'h00, 32'h10, 32'h00, 32'h00, 32'h00};

    assign hready = hreadyout;

    cwt_timer dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .timer_tick(timer_tick), .irq_ack(irq_ack), .irq_req(irq_req),
        .wave_pin_a(pin_a), .wave_pin_a_oe_n(oe_a_n),
        .wave_pin_b(pin_b), .wave_pin_b_oe_n(oe_b_n)
    );

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic conclude();
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        haddr  <= a;
        hwrite <= w;
        htrans <= cwt_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        cmp(r & m, e);
    endtask

    task automatic tk(input int n);
        timer_tick <= 1'b1;
        repeat (n) @(posedge hclk);
        timer_tick <= 1'b0;
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        hresetn = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        timer_tick = 1'b0;
        irq_ack = 3'h0;
        repeat (8) @(posedge hclk);
        cmp({27'h0, hreadyout, pin_a, pin_b, oe_a_n, oe_b_n}, 32'h3);
        hresetn <= 1'b1;
        chk(cwt_pkg::OFS_PINS, 32'h30, 32'h0);
        chk(8'h20, 32'hFFFFFFFF, 32'h0);
        wr(cwt_pkg::OFS_PINS, 32'h1);
        wr(cwt_pkg::OFS_CTRL, 32'h100);
        wr(cwt_pkg::OFS_CMPA, 32'h10);
        wr(cwt_pkg::OFS_COUNT, 32'hFE);
        tk(2);
        chk(cwt_pkg::OFS_COUNT, 32'hFF, 32'h00);
        chk(cwt_pkg::OFS_FLAGS, 32'h3, 32'h1);
        wr(cwt_pkg::OFS_FLAGS, 32'h0);
        chk(cwt_pkg::OFS_FLAGS, 32'h3, 32'h1);
        wr(cwt_pkg::OFS_FLAGS, 32'h1);
        chk(cwt_pkg::OFS_FLAGS, 32'h3, 32'h0);
        tk(17);
        chk(cwt_pkg::OFS_COUNT, 32'hFF, 32'h11);
        chk(cwt_pkg::OFS_FLAGS, 32'h3, 32'h2);
        timer_tick <= 1'b1;
        wr(cwt_pkg::OFS_COUNT, 32'h80);
        timer_tick <= 1'b0;
        chk(cwt_pkg::OFS_COUNT, 32'hFF, 32'h80);
        wr(cwt_pkg::OFS_CTRL, 32'h000);
        tk(5);
        chk(cwt_pkg::OFS_COUNT, 32'hFF, 32'h80);
        wr(cwt_pkg::OFS_FLAGS, 32'h7);
        wr(cwt_pkg::OFS_CMPA, 32'h30);
        wr(cwt_pkg::OFS_COUNT, 32'h30);
        wr(cwt_pkg::OFS_CTRL, 32'h100);
        tk(1);
        chk(cwt_pkg::OFS_FLAGS, 32'h3, 32'h0);
        chk(cwt_pkg::OFS_COUNT, 32'hFF, 32'h31);
        wr(cwt_pkg::OFS_CMPA, 32'h3);
        wr(cwt_pkg::OFS_COUNT, 32'h0);
        wr(cwt_pkg::OFS_CTRL, 32'h112);
        tk(4);
        chk(cwt_pkg::OFS_COUNT, 32'hFF, 32'h0);
        chk(cwt_pkg::OFS_PINS, 32'h10, 32'h10);
        cmp({30'h0, pin_a, oe_a_n}, 32'h2);
        tk(4);
        chk(cwt_pkg::OFS_PINS, 32'h10, 32'h0);
        wr(cwt_pkg::OFS_FLAGS, 32'h7);
        wr(cwt_pkg::OFS_COUNT, 32'h5);
        tk(251);
        chk(cwt_pkg::OFS_FLAGS, 32'h3, 32'h1);
        tk(4);
        chk(cwt_pkg::OFS_FLAGS, 32'h3, 32'h3);
        wr(cwt_pkg::OFS_CTRL, 32'h010);
        chk(cwt_pkg::OFS_PINS, 32'h10, 32'h10);
        wr(cwt_pkg::OFS_FLAGS, 32'h7);
        for (int i = 0; i < 5; i++) begin
            wr(cwt_pkg::OFS_CTRL, fc[i]);
            wr(cwt_pkg::OFS_FORCE, 32'h1);
            chk(cwt_pkg::OFS_PINS, 32'h10, fs[i]);
        end
        chk(cwt_pkg::OFS_FLAGS, 32'h3, 32'h0);
        chk(cwt_pkg::OFS_FORCE, 32'hFFFFFFFF, 32'h0);
        wr(cwt_pkg::OFS_CTRL, 32'h000);
        wr(cwt_pkg::OFS_PINS, 32'h5);
        chk(cwt_pkg::OFS_PINS, 32'h10, 32'h0);
        cmp({30'h0, pin_a, oe_a_n}, 32'h2);
        wr(cwt_pkg::OFS_CTRL, 32'h103);
        wr(cwt_pkg::OFS_CMPA, 32'h44);
        chk(cwt_pkg::OFS_CMPA, 32'hFF, 32'h44);
        wr(cwt_pkg::OFS_COUNT, 32'h40);
        wr(cwt_pkg::OFS_FLAGS, 32'h7);
        tk(6);
        chk(cwt_pkg::OFS_FLAGS, 32'h3, 32'h0);
        wr(cwt_pkg::OFS_CTRL, 32'h100);
        wr(cwt_pkg::OFS_CMPA, 32'h50);
        wr(cwt_pkg::OFS_IRQEN, 32'h2);
        wr(cwt_pkg::OFS_COUNT, 32'h4E);
        tk(3);
        repeat (2) @(posedge hclk);
        cmp({29'h0, irq_req}, 32'h2);
        irq_ack <= 3'h2;
        @(posedge hclk);
        irq_ack <= 3'h0;
        @(posedge hclk);
        cmp({29'h0, irq_req}, 32'h0);
        chk(cwt_pkg::OFS_FLAGS, 32'h2, 32'h0);
        wr(cwt_pkg::OFS_CTRL, 32'h0C0);
        wr(cwt_pkg::OFS_PINS, 32'h2);
        wr(cwt_pkg::OFS_FORCE, 32'h2);
        chk(cwt_pkg::OFS_PINS, 32'h20, 32'h20);
        cmp({30'h0, pin_b, oe_b_n}, 32'h2);
        wr(cwt_pkg::OFS_CTRL, 32'h180);
        wr(cwt_pkg::OFS_CMPB, 32'h20);
        wr(cwt_pkg::OFS_COUNT, 32'h1E);
        tk(3);
        chk(cwt_pkg::OFS_FLAGS, 32'h7, 32'h4);
        chk(cwt_pkg::OFS_PINS, 32'h20, 32'h0);
        cmp({30'h0, pin_b, oe_b_n}, 32'h0);
        conclude();
    end
endmodule
